// ==== lpw_pkg.sv ====
// Shared constants and state types for the bus write-cycle target and its host
package lpw_pkg;
	localparam logic [3:0] START_MEM       = 4'h0;  // Memory-type cycle start
	localparam logic [3:0] START_FWH_WR    = 4'hE;  // Firmware-memory write start
	localparam logic [3:0] ABORT_NIB       = 4'hF;
	localparam logic [3:0] SYNC_READY      = 4'h0;
	localparam logic [3:0] TAR_NIB         = 4'hF;
	localparam logic [3:0] SIZE_ONE_BYTE   = 4'h0;
	localparam logic [3:0] LAD_PULL        = 4'hF;  // Level of an undriven bus
	localparam logic [1:0] CTYPE_MEM       = 2'h1;  // Upper cycle-type bits
	localparam int         CTYPE_WR_BIT    = 1;
	localparam logic [2:0] MEM_ADDR_LAST   = 3'h7;  // Eight address nibbles
	localparam logic [2:0] FWH_ADDR_LAST   = 3'h6;  // Seven address nibbles
	localparam int         SEL_ARRAY_BIT   = 22;
	localparam logic [7:0] MEM_TOP_PREFIX  = 8'hFF;
	localparam logic [14:0] BOOT_WIN_PREFIX = 15'h0007; // 000E_0000 .. 000F_FFFF
	localparam logic [19:0] ARRAY_BOUNDARY = 20'h20000;
	localparam int         HOST_NIBS       = 12;    // Host-driven nibbles before turnaround
	localparam logic [3:0] HOST_NIB_LAST   = 4'hB;
	localparam logic [3:0] HOST_SYNC_WAIT_CYC = 4'h8;

	typedef enum logic [3:0] {
		D_IDLE  = 4'h0,
		D_TYPE  = 4'h1,
		D_SELECT = 4'h2,
		D_ADDR  = 4'h3,
		D_SIZE  = 4'h4,
		D_DLO   = 4'h5,
		D_DHI   = 4'h6,
		D_TAR0  = 4'h7,
		D_TAR1  = 4'h8,
		D_SYNC  = 4'h9,
		D_TARO  = 4'hA
	} lpw_dev_state_e;

	typedef enum logic [2:0] {
		H_IDLE  = 3'h0,
		H_SEND  = 3'h1,
		H_TAR0  = 3'h2,
		H_WAIT  = 3'h3,
		H_TARD  = 3'h4,
		H_TEND  = 3'h5,
		H_ABORT = 3'h6
	} lpw_host_state_e;
endpackage

// ==== lpw_if.sv ====
// Shared nibble bus and frame strobe joining the host and the flash target
`timescale 1ns/1ps
interface lpw_if;
	import lpw_pkg::*;
	logic       frame_n;
	logic [3:0] host_lad;
	logic       host_oe;
	logic [3:0] dev_lad;
	logic       dev_oe;
	logic [3:0] lad;

	// Pull-ups hold the lines high when nobody drives
	assign lad = host_oe ? host_lad : (dev_oe ? dev_lad : LAD_PULL);

	modport host (output frame_n, output host_lad, output host_oe, input lad);
	modport dev (input frame_n, input lad, output dev_lad, output dev_oe);
endinterface

// ==== lpw_dev.sv ====
// Flash target end: decodes single-byte write cycles and answers with sync
`timescale 1ns/1ps
// Contract
// - Last nibble under low strobe is start
// - Cycle type 01 upper, bit1 write
// - Eight address nibbles, most significant first
// - Data byte low nibble then high
// - Host drives ones then releases, clock 13
// - Target takes bus in clock 14
// - Target drives zero sync in clock 15
// - Target drives ones, releases; host resumes
// - Fields sampled on the rising edge
// - Strobe low mid-cycle ends cycle at once
// - Host abort nibble returns target to ready
// - Abort keeps protected command sequence progress
// - No explicit error shown on the bus
// - Select field mismatch ignores whole cycle
// - Firmware address seven nibbles, partial decode
// - Bit 22 picks array or register space
// - Small variant discards writes below boundary
// - Nonzero size field ignores the cycle
// - Accepted cycles run to completion unless strobe goes low mid-cycle
// - Busy device completes cycle, executes no write
// - Start 1110 is firmware write, field order
// - Memory-cycle ID bits are inverted strap
module lpw_dev
	import lpw_pkg::*;
#(
	parameter int TOP_ARRAY_ADDRESS_BIT = 18,
	parameter bit THREE_MBIT            = 1'b0
) (
	input  wire logic                         clk_i,
	input  wire logic                         rst_i,
	lpw_if.dev                                bus,
	input  wire logic [3:0]                   strap_identity_pins_i,
	input  wire logic                         busy_i,
	output logic                              wr_valid_o,
	output logic                              wr_to_array_o,
	output logic                              wr_fwh_o,
	output logic [TOP_ARRAY_ADDRESS_BIT:0]    wr_addr_o,
	output logic [7:0]                        wr_data_o
);
	lpw_dev_state_e state_ff;
	lpw_dev_state_e nxt_state;
	logic [3:0]     id_meta_ff;
	logic [3:0]     id_ff;
	logic [31:0]    addr_ff;
	logic [31:0]    nxt_addr;
	logic [2:0]     cnt_ff;
	logic           fwh_ff;
	logic [7:0]     data_ff;
	logic           wr_valid_ff;
	logic           oe_ff;
	logic [3:0]     lad_ff;
	logic           below_bound;
	logic           drive_next;

	// Address must sit in the top window with inverted ID bits, or the boot window for device 0
	function automatic logic mem_hit(input logic [31:0] a, input logic [3:0] id);
		logic id_ok;
		logic boot_ok;
		id_ok   = (a[31:24] == MEM_TOP_PREFIX) && ({a[23], a[21:19]} == ~id);
		// Low boot window answers only for the boot device
		boot_ok = (id == 4'h0) && (a[31:17] == BOOT_WIN_PREFIX);
		return id_ok || boot_ok;
	endfunction

	// Offset widened to 32 bits so any array size compares without a zero-width pad
	function automatic logic below_boundary(input logic [31:0] a);
		logic [31:0] offs;
		offs = 32'h0;
		for (int b = 0; b <= TOP_ARRAY_ADDRESS_BIT; b++) begin
			offs[b] = a[b];
		end
		return offs < {12'h000, ARRAY_BOUNDARY};
	endfunction

	// Straps are static pins from outside the clock domain
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			id_meta_ff <= 4'h0;
			id_ff      <= 4'h0;
		end else begin
			id_meta_ff <= strap_identity_pins_i;
			id_ff      <= id_meta_ff;
		end
	end

	assign nxt_addr = {addr_ff[27:0], bus.lad};

	always_comb begin
		nxt_state = state_ff;
		if (!bus.frame_n) begin
			// Any low-strobe clock restarts decoding, which also ends a running cycle
			if (bus.lad == START_MEM) begin
				nxt_state = D_TYPE;
			end else if (bus.lad == START_FWH_WR) begin
				nxt_state = D_SELECT;
			end else begin
				nxt_state = D_IDLE;
			end
		end else begin
			case (state_ff)
				D_IDLE: nxt_state = D_IDLE;
				D_TYPE: begin
					if (bus.lad[3:2] == CTYPE_MEM && bus.lad[CTYPE_WR_BIT]) begin
						nxt_state = D_ADDR;
					end else begin
						// Read cycle types land here too: this target only takes writes
						nxt_state = D_IDLE;
					end
				end
				D_SELECT: nxt_state = (bus.lad == id_ff) ? D_ADDR : D_IDLE;
				D_ADDR: begin
					if (cnt_ff == (fwh_ff ? FWH_ADDR_LAST : MEM_ADDR_LAST)) begin
						if (fwh_ff) begin
							nxt_state = D_SIZE;
						end else begin
							nxt_state = mem_hit(nxt_addr, id_ff) ? D_DLO : D_IDLE;
						end
					end
				end
				D_SIZE: nxt_state = (bus.lad == SIZE_ONE_BYTE) ? D_DLO : D_IDLE;
				D_DLO:  nxt_state = D_DHI;
				D_DHI:  nxt_state = D_TAR0;
				D_TAR0: nxt_state = D_TAR1; // host turnaround, not checked
				D_TAR1: nxt_state = D_SYNC;
				D_SYNC: nxt_state = D_TARO;
				D_TARO: nxt_state = D_IDLE;
				default: nxt_state = D_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff <= D_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Address nibble count
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_ff  <= 3'h0;
			addr_ff <= 32'h0;
		end else if (nxt_state == D_TYPE || nxt_state == D_SELECT) begin
			cnt_ff  <= 3'h0;
			addr_ff <= 32'h0;
		end else if (state_ff == D_ADDR && bus.frame_n) begin
			cnt_ff  <= cnt_ff + 3'h1;
			addr_ff <= nxt_addr;
		end
	end

	// Cycle flavour is kept until the next start so the user side reads it with the pulse
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			fwh_ff <= 1'b0;
		end else if (nxt_state == D_TYPE || nxt_state == D_SELECT) begin
			fwh_ff <= (nxt_state == D_SELECT);
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			data_ff <= 8'h0;
		end else if (bus.frame_n && state_ff == D_DLO) begin
			data_ff[3:0] <= bus.lad;
		end else if (bus.frame_n && state_ff == D_DHI) begin
			data_ff[7:4] <= bus.lad;
		end
	end

	// Only the small variant has a hole at the bottom of the array
	assign below_bound = THREE_MBIT && addr_ff[SEL_ARRAY_BIT] && below_boundary(addr_ff);

	// Write is handed on when the sync goes out; busy or out-of-range writes are dropped silently
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_valid_ff <= 1'b0;
		end else begin
			wr_valid_ff <= (nxt_state == D_SYNC) && !busy_i && !below_bound;
		end
	end

	// Enable is registered so the target never overlaps the host's last driven clock
	assign drive_next = (nxt_state == D_TAR1) || (nxt_state == D_SYNC) || (nxt_state == D_TARO);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			oe_ff  <= 1'b0;
			lad_ff <= TAR_NIB;
		end else begin
			oe_ff  <= drive_next;
			lad_ff <= (nxt_state == D_SYNC) ? SYNC_READY : TAR_NIB;
		end
	end

	assign bus.dev_oe    = oe_ff;
	assign bus.dev_lad   = lad_ff;
	assign wr_valid_o    = wr_valid_ff;
	// Sequence progress lives in the command decoder; abort only drops this pulse
	assign wr_to_array_o = addr_ff[SEL_ARRAY_BIT];
	assign wr_fwh_o      = fwh_ff;
	assign wr_addr_o     = addr_ff[TOP_ARRAY_ADDRESS_BIT:0];
	assign wr_data_o     = data_ff;
endmodule // lpw_dev

// ==== lpw_host.sv ====
// Host end: issues one write cycle, waits for sync, aborts on timeout or request
`timescale 1ns/1ps
module lpw_host
	import lpw_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	lpw_if.host              bus,
	input  wire logic        req_valid_i,
	output logic             req_ready_o,
	input  wire logic        req_fwh_i,
	input  wire logic [31:0] req_addr_i,
	input  wire logic [3:0]  req_select_i,
	input  wire logic [3:0]  req_size_i,
	input  wire logic [7:0]  req_data_i,
	input  wire logic        abort_i,
	output logic             done_o,
	output logic             acked_o
);
	lpw_host_state_e state_ff;
	logic [3:0]      seq_ff [HOST_NIBS];
	logic [3:0]      idx_ff;
	logic [3:0]      wait_ff;
	logic            done_ff;
	logic            acked_ff;
	logic            busy;

	assign busy        = (state_ff != H_IDLE);
	assign req_ready_o = !busy;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			for (int i = 0; i < HOST_NIBS; i++) begin
				seq_ff[i] <= 4'h0;
			end
		end else if (req_valid_i && !busy) begin
			if (req_fwh_i) begin
				seq_ff[0] <= START_FWH_WR;
				seq_ff[1] <= req_select_i;
				for (int i = 0; i < 7; i++) begin
					seq_ff[2 + i] <= req_addr_i[27 - 4 * i -: 4];
				end
				seq_ff[9] <= req_size_i;
			end else begin
				seq_ff[0] <= START_MEM;
				seq_ff[1] <= {CTYPE_MEM, 2'b10};
				for (int i = 0; i < 8; i++) begin
					seq_ff[2 + i] <= req_addr_i[31 - 4 * i -: 4];
				end
			end
			seq_ff[10] <= req_data_i[3:0];
			seq_ff[11] <= req_data_i[7:4];
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state_ff <= H_IDLE;
			idx_ff   <= 4'h0;
			wait_ff  <= 4'h0;
			done_ff  <= 1'b0;
			acked_ff <= 1'b0;
		end else begin
			done_ff <= 1'b0;
			if (busy && state_ff != H_ABORT && abort_i) begin
				state_ff <= H_ABORT;
				acked_ff <= 1'b0;
			end else begin
				case (state_ff)
					H_IDLE: begin
						if (req_valid_i) begin
							state_ff <= H_SEND;
							idx_ff   <= 4'h0;
							acked_ff <= 1'b0;
						end
					end
					H_SEND: begin
						idx_ff <= idx_ff + 4'h1;
						if (idx_ff == HOST_NIB_LAST) begin
							state_ff <= H_TAR0;
						end
					end
					H_TAR0: begin
						state_ff <= H_WAIT;
						wait_ff  <= 4'h0;
					end
					H_WAIT: begin
						wait_ff <= wait_ff + 4'h1;
						// The device's own turnaround shows as ones, so only zero is sync
						if (bus.lad == SYNC_READY) begin
							state_ff <= H_TARD;
							acked_ff <= 1'b1;
						end else if (wait_ff == HOST_SYNC_WAIT_CYC - 4'h1) begin
							state_ff <= H_ABORT;
						end
					end
					H_TARD: state_ff <= H_TEND;
					H_TEND: begin
						state_ff <= H_IDLE;
						done_ff  <= 1'b1;
					end
					H_ABORT: begin
						state_ff <= H_IDLE;
						done_ff  <= 1'b1;
					end
					default: state_ff <= H_IDLE;
				endcase
			end
		end
	end

	assign bus.frame_n  = !((state_ff == H_SEND && idx_ff == 4'h0) || state_ff == H_ABORT);
	assign bus.host_oe  = (state_ff == H_SEND) || (state_ff == H_TAR0) || (state_ff == H_ABORT);
	assign bus.host_lad = (state_ff == H_SEND) ? seq_ff[idx_ff] : ABORT_NIB;
	assign done_o       = done_ff;
	assign acked_o      = acked_ff;
endmodule // lpw_host

// ==== lpw_chk.sv ====
// Assertions on the shared nibble bus between host and flash target
`timescale 1ns/1ps
module lpw_chk
	import lpw_pkg::*;
#(
	parameter logic [3:0] STRAP = 4'h5
) (
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       frame_n,
	input wire logic [3:0] host_lad,
	input wire logic       host_oe,
	input wire logic [3:0] dev_lad,
	input wire logic       dev_oe,
	input wire logic [3:0] lad
);
	logic start_seen;
	logic fwh_start;

	assign start_seen = !frame_n && (lad == START_MEM || lad == START_FWH_WR);
	assign fwh_start  = !frame_n && lad == START_FWH_WR;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	chk_single_driver: assert property (!(host_oe && dev_oe))
		else $error("both ends drive the bus");
	chk_sync_zero: assert property (dev_oe && $past(dev_oe) && !$past(dev_oe, 2) |-> dev_lad == SYNC_READY)
		else $error("sync nibble not zero");
	chk_tar_release: assert property ($rose(dev_oe) |-> dev_lad == TAR_NIB ##2 dev_lad == TAR_NIB ##1 !dev_oe)
		else $error("target turnaround wrong");
	chk_frame_ends: assert property (!frame_n |=> !dev_oe)
		else $error("target drives after strobe low");
	chk_answer_time: assert property ($rose(dev_oe) |-> $past(start_seen, 13))
		else $error("answer not 13 clocks after start");
	chk_size_refuse: assert property (fwh_start ##1 frame_n [*8] ##1 (frame_n && lad != SIZE_ONE_BYTE)
		|-> ##4 !dev_oe [*3])
		else $error("answer to bad size field");
	chk_select_refuse: assert property (fwh_start ##1 (frame_n && lad != STRAP) |-> ##12 !dev_oe [*3])
		else $error("answer to other select field");
	chk_host_tar: assert property ($fell(host_oe) |-> $past(host_lad) == TAR_NIB)
		else $error("host released without ones");
endmodule // lpw_chk

// ==== test_lpc_target_write_abort_checks.sv ====
// Self-checking bench: host and flash target joined over the nibble bus
`timescale 1ns/1ps
module test_lpc_target_write_abort_checks;
	import lpw_pkg::*;
	localparam logic [3:0] STRAP = 4'h5;
	logic        clk_i       = 1'b0;
	logic        rst_i       = 1'b1;
	logic        req_valid_i = 1'b0;
	logic        req_fwh_i   = 1'b0;
	logic        abort_i     = 1'b0;
	logic        busy_i      = 1'b0;
	logic [31:0] req_addr_i  = 32'h0;
	logic [3:0]  req_select_i = 4'h0;
	logic [3:0]  strap        = STRAP;
	logic [3:0]  req_size_i  = 4'h0;
	logic [7:0]  req_data_i  = 8'h0;
	logic        req_ready_o, done_o, acked_o, wr_valid_o, wr_to_array_o, wr_fwh_o;
	logic [18:0] wr_addr_o, cap_addr;
	logic [7:0]  wr_data_o, cap_data;
	logic        cap_arr, cap_fwh;
	logic [47:0] sh;
	int          npulse, noe, nsync, mismatches, n_tests;

	always #20 clk_i = ~clk_i;

	lpw_if bus_if();
	lpw_host lpw_host_inst(.clk_i, .rst_i, .bus(bus_if), .req_valid_i, .req_ready_o, .req_fwh_i, .req_addr_i,
		.req_select_i, .req_size_i, .req_data_i, .abort_i, .done_o, .acked_o);
	// Small variant so the boundary refusal can be seen at the user side
	lpw_dev #(.TOP_ARRAY_ADDRESS_BIT(18), .THREE_MBIT(1'b1)) lpw_dev_inst(.clk_i, .rst_i, .bus(bus_if),
		.strap_identity_pins_i(strap), .busy_i, .wr_valid_o, .wr_to_array_o, .wr_fwh_o, .wr_addr_o, .wr_data_o);
	lpw_chk #(.STRAP(STRAP)) lpw_chk_inst(.clk_i, .rst_i, .frame_n(bus_if.frame_n), .host_lad(bus_if.host_lad),
		.host_oe(bus_if.host_oe), .dev_lad(bus_if.dev_lad), .dev_oe(bus_if.dev_oe), .lad(bus_if.lad));

	// Watches both user side and wire; host nibbles are kept in arrival order
	always @(posedge clk_i) begin
		if (wr_valid_o === 1'b1) begin
			npulse++;
			{cap_fwh, cap_arr, cap_addr, cap_data} = {wr_fwh_o, wr_to_array_o, wr_addr_o, wr_data_o};
		end
		if (bus_if.dev_oe === 1'b1) noe++;
		if (bus_if.dev_oe === 1'b1 && bus_if.lad === SYNC_READY) nsync++;
		if (bus_if.host_oe === 1'b1) sh = {sh[43:0], bus_if.lad};
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic do_write(input logic fwh, input logic [31:0] addr, input logic [3:0] sel, input logic [3:0] size,
		input logic [7:0] data, input logic ack, input logic pulse, input int abort_at);
		int i;
		@(posedge clk_i);
		#1;
		check(req_ready_o, 1'b1);
		{req_fwh_i, req_addr_i, req_select_i, req_size_i, req_data_i} = {fwh, addr, sel, size, data};
		req_valid_i = 1'b1;
		{npulse, noe, nsync} = '0;
		@(posedge clk_i);
		#1;
		req_valid_i = 1'b0;
		check(req_ready_o, 1'b0);
		for (i = 0; i < 40 && done_o !== 1'b1; i++) begin
			abort_i = (i == abort_at);
			@(posedge clk_i);
			#1;
		end
		abort_i = 1'b0;
		if (i == 40) begin
			mismatches++;
			stop_test();
		end else begin
			check(acked_o, ack);
			check(i, abort_at >= 0 ? abort_at + 2 : (ack ? 17 : 14 + HOST_SYNC_WAIT_CYC));
			check(req_ready_o, 1'b1);
			check(npulse, pulse);
			check(noe, ack ? 3 : 0);
			check(nsync, ack);
			if (ack) begin
				check({sh[7:4], sh[11:8]}, data);
				check(fwh ? sh[43:16] : sh[43:12], fwh ? addr[27:0] : addr);
			end
			if (pulse) begin
				check({cap_fwh, cap_arr, cap_addr, cap_data}, {fwh, addr[22], addr[18:0], data});
			end
		end
	endtask

	task automatic t_memory();
		do_write(1'b0, 32'hFFD3A5C5, 4'h0, 4'h0, 8'hA5, 1'b1, 1'b1, -1);
		do_write(1'b0, 32'hFF900123, 4'h0, 4'h0, 8'h3C, 1'b1, 1'b1, -1);
	endtask

	task automatic t_firmware();
		do_write(1'b1, 32'h0FC2ABCD, STRAP, 4'h0, 8'h96, 1'b1, 1'b1, -1);
	endtask

	task automatic t_refusals();
		do_write(1'b0, 32'hFFD80000, 4'h0, 4'h0, 8'h11, 1'b0, 1'b0, -1);
		do_write(1'b1, 32'h00400010, 4'h6, 4'h0, 8'h22, 1'b0, 1'b0, -1);
		do_write(1'b1, 32'h00400010, STRAP, 4'h1, 8'h33, 1'b0, 1'b0, -1);
	endtask

	task automatic t_boundary();
		do_write(1'b0, 32'hFFD1FFFF, 4'h0, 4'h0, 8'h44, 1'b1, 1'b0, -1);
		do_write(1'b0, 32'hFFD20000, 4'h0, 4'h0, 8'h55, 1'b1, 1'b1, -1);
	endtask

	task automatic t_busy();
		busy_i = 1'b1;
		do_write(1'b0, 32'hFFD3A5C5, 4'h0, 4'h0, 8'h66, 1'b1, 1'b0, -1);
		busy_i = 1'b0;
	endtask

	task automatic t_boot();
		strap = 4'h0;
		do_write(1'b0, 32'h000E1234, 4'h0, 4'h0, 8'h5A, 1'b1, 1'b1, -1);
		do_write(1'b0, 32'hFFD3A5C5, 4'h0, 4'h0, 8'h6B, 1'b0, 1'b0, -1);
		strap = STRAP;
	endtask

	task automatic t_abort();
		do_write(1'b0, 32'hFFD3A5C5, 4'h0, 4'h0, 8'h77, 1'b0, 1'b0, 4);
		do_write(1'b0, 32'hFFD3A5C5, 4'h0, 4'h0, 8'h77, 1'b1, 1'b1, -1);
	endtask

	initial begin
		repeat (6) @(posedge clk_i);
		#1;
		rst_i = 1'b0;
		repeat (3) @(posedge clk_i);
		t_memory();
		t_firmware();
		t_refusals();
		t_boundary();
		t_busy();
		t_boot();
		t_abort();
		stop_test();
	end
endmodule // test_lpc_target_write_abort_checks
